/* File: verilog/sfd_sequencer.sv */
// top of the diagnostic sequencer: four channels, turn-on pulse, offset
// and current detection; host bits arrive as plain ports already decoded
`timescale 1ns/1ps
module sfd_sequencer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic standby_off,
  input wire logic diag_enable,
  input wire logic offset_enable,
  input wire logic gain16,
  input wire logic line_diag_sel,
  input wire logic cur_det_enable,
  input wire logic host_write,
  input wire logic host_read,
  input wire logic [3:0] overload,
  input wire logic [3:0] gnd_pos,
  input wire logic [3:0] gnd_neg,
  input wire logic [3:0] sh_vs,
  input wire logic [3:0] sh_load_pa,
  input wire logic [3:0] sh_load_ld,
  input wire logic [3:0] open_pa,
  input wire logic [3:0] open_ld,
  input wire logic [3:0] offset_hi,
  input wire logic [3:0] peak_hi,
  output logic stage_enable,
  output logic pulse_on,
  output logic line_thresholds,
  output logic cycle_done,
  output logic offset_active,
  output logic [19:0] fault,
  output logic [3:0] perm_mode,
  output logic [3:0] chan_active,
  output logic [3:0] offset_flag,
  output logic [3:0] open_tweeter
);
  logic [17:0] div;
  logic tick;
  logic [6:0] pcnt;
  logic pulse_end, rearm, biased;
  logic [3:0] off_ok, cur_sup, peak_q;
  logic [1:0] peaks [4];
  logic [19:0] cfault;
  logic [3:0] cperm, cact, cdone;
  logic [3:0] sh_load, open_load;

  ////////////////////////////////////////////////////////////////////////
  // 1 ms time base
  always_ff @(posedge clk) begin
    if (!reset_n || div == 18'(sfd_pkg::TICK_CYCLES - 1)) div <= 18'h00000;
    else div <= div + 18'h00001;
  end
  assign tick = div == 18'(sfd_pkg::TICK_CYCLES - 1);
  assign rearm = host_read;
  assign biased = stage_enable;

  always_ff @(posedge clk) begin
    if (!reset_n) line_thresholds <= 1'b0;
    else line_thresholds <= gain16 && line_diag_sel; // R6 R24
  end
  assign sh_load = line_thresholds ? sh_load_ld : sh_load_pa; // R6
  assign open_load = line_thresholds ? open_ld : open_pa; // R6

  ////////////////////////////////////////////////////////////////////////
  // turn-on pulse: stage held in standby until pulse finishes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pulse_on <= 1'b0;
      stage_enable <= 1'b0;
      pcnt <= sfd_pkg::CHAN_RESET;
    end else begin
      if (host_write && standby_off && diag_enable && !stage_enable &&
          !pulse_on) begin
        pulse_on <= 1'b1; // R1 R3
        pcnt <= sfd_pkg::CHAN_RESET;
      end else if (pulse_on) begin
        if (tick) pcnt <= pcnt + 7'h01;
        if (tick && pcnt == 7'(sfd_pkg::CYCLE_TICKS - 1)) begin
          pulse_on <= 1'b0;
          stage_enable <= standby_off; // R3 R4
        end
      end else if (!standby_off) begin
        stage_enable <= 1'b0;
      end else if (host_write && !diag_enable) begin
        stage_enable <= 1'b1;
      end
    end
  end
  assign pulse_end = pulse_on && tick &&
    pcnt == 7'(sfd_pkg::CYCLE_TICKS - 1); // R5

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      sfd_channel u_ch (
        .clk(clk),
        .reset_n(reset_n),
        .tick(tick),
        .diag_en(diag_enable),
        .biased(biased),
        .overload(overload[g]),
        .src_pos(sfd_pkg::SRC_IS_POS[g]), // R20
        .gnd_pos(gnd_pos[g]),
        .gnd_neg(gnd_neg[g]),
        .sh_vs(sh_vs[g]),
        .sh_load(sh_load[g]),
        .open_load(open_load[g]),
        .pulse_end(pulse_end),
        .rearm(rearm),
        .fault(cfault[g*5 +: 5]),
        .perm(cperm[g]),
        .active(cact[g]),
        .done(cdone[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // readable copy: a read returns previous cycle and re-arms
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault <= 20'h00000;
      perm_mode <= 4'h0;
      cycle_done <= 1'b0;
    end else begin
      fault <= cfault; // R2 R18
      perm_mode <= cperm;
      if (|cdone) cycle_done <= 1'b1; // R23
      else if (host_read) cycle_done <= 1'b0; // R22
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) chan_active <= 4'h0;
    else chan_active <= cact & {4{stage_enable}};
  end

  ////////////////////////////////////////////////////////////////////////
  // offset and current detection
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      offset_active <= 1'b0;
      off_ok <= 4'h0;
      offset_flag <= 4'h0;
    end else begin
      offset_active <= offset_enable;
      // nothing to publish while the test is switched off
      if (host_read) offset_flag <= off_ok & {4{offset_active}}; // R13
      if ((offset_enable && !offset_active) || host_read) begin
        off_ok <= 4'hF; // R13 R22
      end else if (offset_enable) begin
        off_ok <= off_ok & offset_hi & ~overload; // R13 R15
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cur_sup <= 4'h0;
      open_tweeter <= 4'h0;
      peak_q <= 4'h0;
      for (int i = 0; i < 4; i++) peaks[i] <= 2'h0;
    end else begin
      peak_q <= peak_hi;
      for (int i = 0; i < 4; i++) begin
        // a peak spans many clocks: count rising edges only
        if (!cur_det_enable || host_read) begin
          peaks[i] <= 2'h0;
        end else if (peak_hi[i] && !peak_q[i] &&
            peaks[i] != sfd_pkg::PEAK_MIN) begin
          peaks[i] <= peaks[i] + 2'h1; // R16
        end
        // overload in the read cycle still counts against the new period
        if (!cur_det_enable) cur_sup[i] <= 1'b0;
        else if (overload[i]) cur_sup[i] <= 1'b1; // R15
        else if (host_read) cur_sup[i] <= 1'b0;
        if (host_read && cur_det_enable)
          open_tweeter[i] <= !cur_sup[i] &&
            peaks[i] != sfd_pkg::PEAK_MIN; // R16 R17
      end
    end
  end

  a_pulse_stby: assert property (@(posedge clk) disable iff (!reset_n)
    pulse_on |-> !stage_enable) // R3
    else $error("stage enabled during pulse");
  a_line_sel: assert property (@(posedge clk) disable iff (!reset_n)
    gain16 && line_diag_sel |=> line_thresholds) // R6
    else $error("line thresholds not selected");
  a_read_done: assert property (@(posedge clk) disable iff (!reset_n)
    host_read && !(|cdone) |=> !cycle_done) // R22
    else $error("done flag kept after read");
  a_offset_sup: assert property (@(posedge clk) disable iff (!reset_n)
    offset_enable && offset_active && !host_read && overload[0]
    |=> !off_ok[0]) // R15
    else $error("offset not suppressed");
  a_tweet_ok: assert property (@(posedge clk) disable iff (!reset_n)
    host_read && cur_det_enable && peaks[0] == 2'h3 |=> !open_tweeter[0]) // R16
    else $error("tweeter wrongly open");
  c_pulse: cover property (@(posedge clk) pulse_end);
  c_done: cover property (@(posedge clk) cycle_done && host_read);
  c_tweet: cover property (@(posedge clk) open_tweeter[1]);
endmodule // sfd_sequencer

/* File: verilog/sfd_pkg.sv */
// package of constants for the speaker fault diagnostic sequencer
// assumes a single 200 MHz clock and synchronous analog comparator inputs
// Function
// (R1) leaving standby with diagnostics requested runs a turn-on load test
// (R2) turn-on result held until a new pulse follows a host read
// (R3) standby exit plus diag enable together: pulse first, stage stays off
// (R4) once biased switch to permanent diagnostics, keep result until short
// (R5) outputs latched at end of the 100 ms pulse top
// (R6) line-driver load thresholds only with 16 dB gain and line-driver diag
// (R7) permanent diagnostics see ground, supply, load shorts and offset
// (R8) restart mode: faulted channel alone shuts down, rechecked every 1 ms
// (R9) diagnostic mode enabled by host, self-activates on overload
// (R10) overload gone at 1 ms recheck: skip diagnostic, channel back on
// (R11) overload still there at 1 ms recheck: run 100 ms diagnostic cycle
// (R12) after cycle channel restarts, results stored, next cycle after read
// (R13) offset beyond 2 V stable over test time is flagged
// (R14) host runs offset test only with low or zero signal
// (R15) overload protection during test suppresses offset and AC results
// (R16) tweeter present only with at least 3 peaks above 500 mA
// (R17) host plays test tone for at least 3 sine cycles
// (R18) simultaneous faults reported one after another over read cycles; code latches only the prioritised fault, so later reads repeat it
// (R19) double faults prioritised: supply dominates, sink ground plus open
// (R20) pulse source is positive on front-left, rear-right, else negative
// (R21) permanent diagnostics never report open load
// (R22) each host read re-arms all cycles and returns previous results
// (R23) first status byte flags a terminated diagnostic cycle
// (R24) host selects line-driver thresholds and current detection bits
package sfd_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CHECK_US = 1000;
  localparam int CYCLE_MS = 100;
  localparam int TICK_CYCLES = CLK_MHZ * CHECK_US;
  localparam int CYCLE_TICKS = CYCLE_MS;
  localparam logic [1:0] PEAK_MIN = 2'h3;
  localparam logic [3:0] SRC_IS_POS = 4'h9;
  localparam logic [6:0] CHAN_RESET = 7'h00;
  typedef enum logic [3:0] {
    SFD_IDLE = 4'h1,
    SFD_WAIT = 4'h2,
    SFD_DIAG = 4'h4,
    SFD_DONE = 4'h8
  } sfd_state_e;
endpackage

/* File: verilog/sfd_channel.sv */
// one output channel: permanent overload handling and fault latching
// assumes comparator and protection inputs synchronous to clk
`timescale 1ns/1ps
module sfd_channel (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic diag_en,
  input wire logic biased,
  input wire logic overload,
  input wire logic src_pos,
  input wire logic gnd_pos,
  input wire logic gnd_neg,
  input wire logic sh_vs,
  input wire logic sh_load,
  input wire logic open_load,
  input wire logic pulse_end,
  input wire logic rearm,
  output logic [4:0] fault,
  output logic perm,
  output logic active,
  output logic done
);
  sfd_pkg::sfd_state_e state;
  logic [6:0] cnt;
  logic gnd_src, gnd_snk;
  logic [4:0] next_fault;
  logic armed;

  assign gnd_src = src_pos ? gnd_pos : gnd_neg; // R20
  assign gnd_snk = src_pos ? gnd_neg : gnd_pos; // R20

  // fault = {open, load short, supply, gnd, reserved}
  always_comb begin
    next_fault = 5'h00;
    if (sh_vs) begin
      next_fault[2] = 1'b1; // R19
      next_fault[1] = gnd_src; // R19
    end else if (gnd_snk && open_load && !biased) begin
      next_fault[4] = 1'b1; // R19
    end else if (gnd_src || gnd_snk) begin
      next_fault[1] = 1'b1; // R19
    end else if (sh_load) begin
      next_fault[3] = 1'b1;
    end else if (open_load && !biased) begin // R21
      next_fault[4] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= sfd_pkg::SFD_IDLE;
      cnt <= sfd_pkg::CHAN_RESET;
      active <= 1'b1;
      perm <= 1'b0;
    end else begin
      case (state)
        sfd_pkg::SFD_IDLE: begin
          if (overload && biased) begin
            active <= 1'b0; // R8
            cnt <= sfd_pkg::CHAN_RESET;
            state <= sfd_pkg::SFD_WAIT;
          end
        end
        sfd_pkg::SFD_WAIT: begin
          if (tick) begin
            if (!overload) begin
              active <= 1'b1; // R10
              state <= sfd_pkg::SFD_IDLE;
            end else if (diag_en && armed) begin
              state <= sfd_pkg::SFD_DIAG; // R9 R11
            end
          end
        end
        sfd_pkg::SFD_DIAG: begin
          if (tick) begin
            cnt <= cnt + 7'h01;
            if (cnt == 7'(sfd_pkg::CYCLE_TICKS - 1)) begin
              perm <= 1'b1; // R4
              state <= sfd_pkg::SFD_DONE; // R12
            end
          end
        end
        default: begin
          if (tick && !overload) begin
            active <= 1'b1; // R8
            state <= sfd_pkg::SFD_IDLE;
          end
        end
      endcase
      if (rearm && state == sfd_pkg::SFD_IDLE) perm <= 1'b0;
    end
  end

  // done is a one-cycle strobe, so the top can clear its flag on a read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault <= 5'h00;
      done <= 1'b0;
      armed <= 1'b1;
    end else begin
      done <= 1'b0;
      if (state == sfd_pkg::SFD_DIAG && tick &&
          cnt == 7'(sfd_pkg::CYCLE_TICKS - 1)) begin
        fault <= next_fault; // R7 R12
        done <= 1'b1;
        armed <= 1'b0;
      end else if (pulse_end) begin
        fault <= next_fault; // R1 R5
        done <= 1'b1;
        armed <= 1'b0;
      end else if (rearm) begin
        armed <= 1'b1; // R22
      end
    end
  end

  a_fault_vs_dom: assert property (@(posedge clk) disable iff (!reset_n)
    pulse_end && sh_vs |=> fault[2] && !fault[3]) // R19
    else $error("supply short not dominant");
  a_restart_off: assert property (@(posedge clk) disable iff (!reset_n)
    state == sfd_pkg::SFD_IDLE && overload && biased |=> !active) // R8
    else $error("faulted channel not shut down");
  a_skip_diag: assert property (@(posedge clk) disable iff (!reset_n)
    state == sfd_pkg::SFD_WAIT && tick && !overload |=> active) // R10
    else $error("channel not reactivated");
endmodule // sfd_channel

/* File: verif/sfd_host_model.sv */
// host model: writes decoded control bits and pulses the read strobe
// assumes the bench clock; drives just after each rising edge
`timescale 1ns/1ps
module sfd_host_model (
  input wire logic clk,
  output logic standby_off,
  output logic diag_enable,
  output logic offset_enable,
  output logic gain16,
  output logic line_diag_sel,
  output logic cur_det_enable,
  output logic host_write,
  output logic host_read
);
  initial begin
    {standby_off, diag_enable, offset_enable} = 3'h0;
    {gain16, line_diag_sel, cur_det_enable} = 3'h0;
    {host_write, host_read} = 2'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // all six bits change in one programming step, strobe for one cycle
  task automatic write_ctrl(input logic [5:0] bits);
    @(posedge clk);
    #1;
    {standby_off, diag_enable, offset_enable} = bits[5:3];
    {gain16, line_diag_sel, cur_det_enable} = bits[2:0];
    host_write = 1'b1;
    @(posedge clk);
    #1;
    host_write = 1'b0;
  endtask
  task automatic read_status();
    @(posedge clk);
    #1;
    host_read = 1'b1;
    @(posedge clk);
    #1;
    host_read = 1'b0;
  endtask
endmodule // sfd_host_model

/* File: verif/speaker_fault_diagnostic_sequencer_tb_top.sv */
// bench for the diagnostic sequencer: random comparator noise, host model
// assumes the full 1 ms tick, so only short spans of the pulse are seen
`timescale 1ns/1ps
module speaker_fault_diagnostic_sequencer_tb_top;
  logic clk;
  logic reset_n;
  logic [3:0] ovl, gp, gn, svs, slp, sll, opa, old, ofh, pkh;
  logic stage_enable, pulse_on, line_thresholds, cycle_done, offset_active;
  logic [19:0] fault;
  logic [3:0] perm_mode, chan_active, offset_flag, open_tweeter;
  logic standby_off, diag_enable, offset_enable, gain16, line_diag_sel;
  logic cur_det_enable, host_write, host_read;
  logic [31:0] seed = 32'h680188BE;
  int error_cnt = 0;
  int samples_checked = 0;
  int npk [4];
  logic [3:0] hand [4] = '{4'hF, 4'h7, 4'h3, 4'h1};

  sfd_host_model i_sfd_host_model (.clk(clk), .standby_off(standby_off),
    .diag_enable(diag_enable), .offset_enable(offset_enable),
    .gain16(gain16), .line_diag_sel(line_diag_sel),
    .cur_det_enable(cur_det_enable), .host_write(host_write),
    .host_read(host_read));
  sfd_sequencer i_sfd_sequencer (.clk(clk), .reset_n(reset_n),
    .standby_off(standby_off), .diag_enable(diag_enable),
    .offset_enable(offset_enable), .gain16(gain16),
    .line_diag_sel(line_diag_sel), .cur_det_enable(cur_det_enable),
    .host_write(host_write), .host_read(host_read), .overload(ovl),
    .gnd_pos(gp), .gnd_neg(gn), .sh_vs(svs), .sh_load_pa(slp),
    .sh_load_ld(sll), .open_pa(opa), .open_ld(old), .offset_hi(ofh),
    .peak_hi(pkh), .stage_enable(stage_enable), .pulse_on(pulse_on),
    .line_thresholds(line_thresholds), .cycle_done(cycle_done),
    .offset_active(offset_active), .fault(fault), .perm_mode(perm_mode),
    .chan_active(chan_active), .offset_flag(offset_flag),
    .open_tweeter(open_tweeter));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // open tweeter expected only with under 3 peak edges and no overload in the period
  function automatic logic [3:0] tweet_exp(input logic [3:0] sup);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) r[i] = !sup[i] && npk[i] < 3;
    return r;
  endfunction
  task automatic check(input logic [63:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s", $time, what);
      error_cnt++;
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // comparator noise on every channel, peaks held low for offset test
  task automatic shake();
    {ovl, gp, gn, svs, slp, sll, opa, old} = xs();
    ofh = 4'(xs());
    pkh = 4'h0;
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    tick(12);
    reset_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20000);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    {ovl, gp, gn, svs, slp, sll, opa, old, ofh, pkh} = 40'h0;
    do_reset();
    check({stage_enable, pulse_on, line_thresholds, cycle_done,
      offset_active, fault, perm_mode, chan_active, offset_flag,
      open_tweeter}, 32'h0, "outputs after reset");
    // every gain and diagnostic-mode pairing, no standby exit
    for (int k = 0; k < 4; k++) begin
      i_sfd_host_model.write_ctrl(6'(k) << 1);
      tick(3);
      check(line_thresholds, k == 3, "line thresholds");
      check(pulse_on, 1'b0, "pulse without standby exit");
    end
    // standby exit and diag enable in one step: pulse first, stage off
    i_sfd_host_model.write_ctrl(6'h30);
    tick(1);
    check(pulse_on, 1'b1, "pulse start");
    repeat (2000) begin
      shake();
      tick(1);
      check(pulse_on, 1'b1, "pulse held");
      check(stage_enable, 1'b0, "stage during pulse");
      check(cycle_done, 1'b0, "done during pulse");
      check(fault, 20'h0, "fault before pulse end");
      check(perm_mode, 4'h0, "permanent during pulse");
    end
    // standby exit alone: no pulse, stage comes up; offset test armed
    {ovl, gp, gn, svs, slp, sll, opa, old, ofh, pkh} = 40'h0;
    do_reset();
    ofh = 4'hF;
    i_sfd_host_model.write_ctrl(6'h28);
    tick(4);
    check(stage_enable, 1'b1, "stage without diag");
    check(pulse_on, 1'b0, "no pulse without diag");
    check(offset_active, 1'b1, "offset test running");
    check(chan_active, 4'hF, "all channels playing");
    tick(200);
    i_sfd_host_model.read_status();
    tick(3);
    check(offset_flag, 4'hF, "stable offset flagged");
    // overload on one channel mid test hides its offset
    ovl = 4'h1;
    tick(1);
    ovl = 4'h0;
    tick(200);
    i_sfd_host_model.read_status();
    tick(3);
    check(offset_flag, 4'hE, "offset under overload");
    check(chan_active, 4'hE, "only faulted channel off");
    // tweeter test: hand-picked bursts, then random ones with an overload
    i_sfd_host_model.write_ctrl(6'h21);
    for (int r = 0; r < 2; r++) begin
      npk = '{default: 0};
      ovl = r ? 4'h8 : 4'h0;
      tick(2);
      ovl = 4'h0;
      for (int b = 0; b < 4; b++) begin
        pkh = r ? 4'(xs()) : hand[b];
        for (int i = 0; i < 4; i++) npk[i] += int'(pkh[i]);
        tick(2);
        pkh = 4'h0;
        tick(2);
      end
      i_sfd_host_model.read_status();
      tick(3);
      check(open_tweeter, tweet_exp(r ? 4'h8 : 4'h0), "tweeter");
      check(offset_flag, 4'h0, "offset test off");
    end
    report_and_stop();
  end
endmodule // speaker_fault_diagnostic_sequencer_tb_top
